// *** hw/lcd_driver_command_decoder.v ***
// Serial slave front end and command decoder of the LCD row/column driver
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cmd_defs.vh"
// Summary of operation
// - Top bit set means another command follows
// - Commands only in writes; reads return data
// - Store data only when subaddress matches own
// - Two low bits pick multiplex rate
// - Two status bits pick blank/normal/on/inverse
// - Type bit picks row-only or mixed
// - Start-bank opcode sets top bank
// - Device select loads subaddress counter
// - Access field sets auto-increment order
// - Access command loads bank pointer
// - Column load sets X pointer
// - One bit per clock, SDA stable high
// - Idle bus leaves both lines released
// - SDA falling with SCL high is start
// - SDA rising with SCL high is stop
// - Unlimited bytes, ninth clock carries acknowledge
// - Acknowledge every received byte but a foreign address
// - Hold SDA low through acknowledge high
// - Release SDA after master withholds acknowledge
module lcd_driver_command_decoder #(
  parameter [6:0] SLAVE_ADDR = `RST_SLAVE_ADDR, // Bus address, plain default
  parameter [3:0] OWN_SUBADDR = 4'h0 // Hardware subaddress of this device
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_srst,
  // Serial bus pins
  input wire i_scl,
  input wire i_sda,
  output reg o_sda,
  output reg o_sda_oe,
  // Display RAM read data for the byte being sent
  input wire [7:0] i_rd_data,
  // Decoded configuration
  output reg [1:0] o_multiplex_rate_field,
  output reg [1:0] o_display_status_field,
  output reg o_mixed_mode,
  output reg [1:0] o_top_bank_field,
  output reg [3:0] o_subaddress_field,
  output reg [1:0] o_access_order_field,
  output reg [1:0] o_bank_select_field,
  output reg [5:0] o_column_field,
  // Display data stream
  output reg [7:0] o_wr_data,
  output reg o_wr_strobe,
  output reg o_rd_strobe,
  output reg o_busy
);
  // Transfer states
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_WACK = 3'h2;
  localparam ST_WBYTE = 3'h3;
  localparam ST_RBYTE = 3'h4;
  localparam ST_RACK = 3'h5;
  localparam ST_SKIP = 3'h6;
  localparam ST_ACKHI = 3'h7;

  wire scl; // Filtered clock line
  wire sda; // Filtered data line
  reg scl_d; // Previous clock level
  reg sda_d; // Previous data level
  reg [2:0] state; // Transfer state
  reg [2:0] after_ack; // State to enter after the acknowledge slot
  reg [3:0] bit_cnt; // Bits moved in current byte
  reg [7:0] shift; // Receive shift register
  reg [7:0] tx; // Transmit shift register
  reg cmd_phase; // Bytes are still commands
  reg reading; // Current transfer is a read
  reg master_nak; // Master withheld acknowledge
  wire is_column;
  wire is_mode;
  wire is_select;
  wire is_access;
  wire is_bank;
  wire [7:0] rx_byte; // Byte completed on this rising edge

  // Synchronise both bus lines
  line_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_pin(i_scl),
    .o_level(scl)
  );
  line_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_pin(i_sda),
    .o_level(sda)
  );

  // Edge and condition detection
  wire scl_rise = scl & ~scl_d; // Data sampled here
  wire scl_fall = ~scl & scl_d; // Data changes here
  wire start_cond = scl & scl_d & sda_d & ~sda;
  wire stop_cond = scl & scl_d & ~sda_d & sda;
  assign rx_byte = {shift[6:0], sda};

  // Classify the byte just received
  cmd_decode u_decode (
    .i_byte(rx_byte),
    .o_is_column(is_column),
    .o_is_mode(is_mode),
    .o_is_select(is_select),
    .o_is_access(is_access),
    .o_is_bank(is_bank)
  );

  // Remember previous line levels
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // Bus protocol engine and command execution
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'hff;
      cmd_phase <= 1'b0;
      reading <= 1'b0;
      master_nak <= 1'b0;
      o_sda <= 1'b0;
      o_sda_oe <= 1'b0;
      o_multiplex_rate_field <= `RST_MUX;
      o_display_status_field <= `RST_STATUS;
      o_mixed_mode <= 1'b0;
      o_top_bank_field <= 2'h0;
      o_subaddress_field <= 4'h0;
      o_access_order_field <= `ORDER_CHAR;
      o_bank_select_field <= 2'h0;
      o_column_field <= 6'h00;
      o_wr_data <= 8'h00;
      o_wr_strobe <= 1'b0;
      o_rd_strobe <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_wr_strobe <= 1'b0;
      o_rd_strobe <= 1'b0;
      if (start_cond) begin
        // Start or repeated start opens address phase
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        o_sda_oe <= 1'b0;
        o_busy <= 1'b1;
      end else if (stop_cond) begin
        // Stop releases the bus
        state <= ST_IDLE;
        o_sda_oe <= 1'b0;
        o_busy <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_WBYTE: begin
            // Sample one bit per rising clock edge
            if (scl_rise) begin
              shift <= rx_byte;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h7) begin
                bit_cnt <= 4'h0;
                if (state == ST_ADDR) begin
                  if (rx_byte[7:1] == SLAVE_ADDR) begin
                    reading <= rx_byte[0];
                    cmd_phase <= ~rx_byte[0];
                    state <= ST_WACK;
                    after_ack <= rx_byte[0] ? ST_RBYTE : ST_WBYTE;
                    if (rx_byte[0]) begin
                      tx <= i_rd_data;
                      o_rd_strobe <= 1'b1;
                    end
                  end else begin
                    state <= ST_SKIP; // Other device addressed
                  end
                end else begin
                  state <= ST_WACK;
                  after_ack <= ST_WBYTE;
                  if (cmd_phase) begin
                    cmd_phase <= rx_byte[`CONT_BIT];
                    if (is_mode) begin
                      o_multiplex_rate_field <= rx_byte[`MODE_MUX_HI:`MODE_MUX_LO];
                      o_display_status_field <=
                        rx_byte[`MODE_STATUS_HI:`MODE_STATUS_LO];
                      o_mixed_mode <= rx_byte[`MODE_TYPE_BIT];
                    end
                    if (is_bank) begin
                      o_top_bank_field <= rx_byte[1:0];
                    end
                    if (is_select) begin
                      o_subaddress_field <= rx_byte[3:0];
                    end
                    if (is_access) begin
                      o_access_order_field <= rx_byte[3:2];
                      o_bank_select_field <= rx_byte[1:0];
                    end
                    if (is_column && rx_byte[5:0] <= `COLUMN_LAST) begin
                      o_column_field <= rx_byte[5:0];
                    end
                  end else if (o_subaddress_field == OWN_SUBADDR) begin
                    o_wr_data <= rx_byte;
                    o_wr_strobe <= 1'b1;
                  end
                end
              end
            end
            // Release after the acknowledge slot has ended
            if (scl_fall && bit_cnt == 4'h0) begin
              o_sda_oe <= 1'b0;
            end
          end
          ST_WACK: begin
            // Pull low through the ninth clock pulse
            if (scl_fall) begin
              o_sda <= 1'b0;
              o_sda_oe <= 1'b1;
            end
            if (scl_rise && o_sda_oe) begin
              state <= ST_ACKHI;
            end
          end
          ST_ACKHI: begin
            // Keep a slave acknowledge low until the acknowledge high phase ends; after a master acknowledge the line stays released
            if (scl_fall) begin
              state <= after_ack;
              if (after_ack == ST_RBYTE) begin
                o_sda <= 1'b0; // Open drain: only ever pulls low, a one is a release
                o_sda_oe <= ~tx[7];
                tx <= {tx[6:0], 1'b1};
                bit_cnt <= 4'h1;
              end else begin
                o_sda_oe <= 1'b0;
              end
            end
          end
          ST_RBYTE: begin
            // Shift out on falling edges, open drain low only
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                o_sda_oe <= 1'b0; // Free line for master acknowledge
                state <= ST_RACK;
              end else begin
                o_sda_oe <= ~tx[7];
                tx <= {tx[6:0], 1'b1};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            // Sample master acknowledge
            if (scl_rise) begin
              master_nak <= sda;
              if (sda) begin
                state <= ST_SKIP;
              end else begin
                tx <= i_rd_data;
                o_rd_strobe <= 1'b1;
                after_ack <= ST_RBYTE;
                state <= ST_ACKHI;
              end
            end
          end
          ST_SKIP: begin
            o_sda_oe <= 1'b0;
          end
          default: begin
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // lcd_driver_command_decoder
`default_nettype wire

// *** inc/lcd_cmd_defs.vh ***
// Constants for the LCD driver command decoder and its serial slave front end
`ifndef LCD_CMD_DEFS_VH
`define LCD_CMD_DEFS_VH
// Command byte layout
`define CONT_BIT 7
`define MODE_TYPE_BIT 4
`define MODE_STATUS_HI 3
`define MODE_STATUS_LO 2
`define MODE_MUX_HI 1
`define MODE_MUX_LO 0
// Multiplex rate codes
`define MUX_8 2'h1
`define MUX_16 2'h2
`define MUX_24 2'h3
`define MUX_32 2'h0
// Display status codes
`define DISP_BLANK 2'h0
`define DISP_NORMAL 2'h1
`define DISP_ALL_ON 2'h2
`define DISP_INVERSE 2'h3
// Access order codes
`define ORDER_CHAR 2'h0
`define ORDER_HALF 2'h1
`define ORDER_FULL 2'h2
// Column range
`define COLUMN_LAST 6'h27
// Reset values
`define RST_MUX 2'h0
`define RST_STATUS 2'h0
`define RST_SLAVE_ADDR 7'h3c
`endif

// *** hw/line_sync.v ***
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
`default_nettype none
module line_sync #(
  parameter RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_srst,
  // Raw pin and filtered level
  input wire i_pin,
  output reg o_level
);
  reg meta; // First stage, read only by the second
  reg s2; // Second stage
  reg s3; // Third stage
  // Shift the pin in; accept a new level once stages two and three agree
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      meta <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
      o_level <= RESET_LEVEL;
    end else begin
      meta <= i_pin;
      s2 <= meta;
      s3 <= s2;
      if (s2 == s3) begin
        o_level <= s3;
      end
    end
  end
endmodule // line_sync
`default_nettype wire

// *** hw/cmd_decode.v ***
// Combinational classifier of one command byte
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cmd_defs.vh"
module cmd_decode (
  // Byte under decode
  input wire [7:0] i_byte,
  // One-hot command kind
  output reg o_is_column,
  output reg o_is_mode,
  output reg o_is_select,
  output reg o_is_access,
  output reg o_is_bank
);
  // Decode opcode bits following the continuation flag
  always @* begin
    o_is_column = 1'b0;
    o_is_mode = 1'b0;
    o_is_select = 1'b0;
    o_is_access = 1'b0;
    o_is_bank = 1'b0;
    if (!i_byte[6]) begin
      o_is_column = 1'b1;
    end else if (!i_byte[5]) begin
      o_is_mode = 1'b1;
    end else if (!i_byte[4]) begin
      o_is_select = 1'b1;
    end else if (i_byte[3:2] == 2'h3) begin
      o_is_bank = 1'b1;
    end else begin
      o_is_access = 1'b1;
    end
  end
endmodule // cmd_decode
`default_nettype wire

// *** verif/lcd_cmd_properties.sv ***
// Port assertions for the LCD command decoder
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cmd_defs.vh"
module lcd_cmd_properties #(
  parameter [3:0] OWN_SUBADDR = 4'h0
) (
  // Clock, reset and pins
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  // Decoded outputs
  input wire logic [1:0] o_multiplex_rate_field,
  input wire logic [1:0] o_display_status_field,
  input wire logic o_mixed_mode,
  input wire logic [1:0] o_top_bank_field,
  input wire logic [3:0] o_subaddress_field,
  input wire logic [1:0] o_access_order_field,
  input wire logic [1:0] o_bank_select_field,
  input wire logic [5:0] o_column_field,
  input wire logic o_wr_strobe,
  input wire logic o_busy
);
  // All configuration outputs in one word
  wire [20:0] cfg = {o_multiplex_rate_field, o_display_status_field, o_mixed_mode,
    o_top_bank_field, o_subaddress_field, o_access_order_field, o_bank_select_field,
    o_column_field};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // Master-made edges of SDA while SCL high
  sequence s_start;
    i_scl && $past(i_scl) && $fell(i_sda) && !o_sda_oe;
  endsequence
  sequence s_stop;
    i_scl && $past(i_scl) && $rose(i_sda) && !o_sda_oe && !$past(o_sda_oe);
  endsequence
  a_oe_only_busy:
    assert property (o_sda_oe |-> o_busy) else $error("SDA driven while idle");
  a_drive_low:
    assert property (o_sda_oe |-> !o_sda) else $error("SDA driven high");
  a_col_range:
    assert property (o_column_field <= `COLUMN_LAST) else $error("column above range");
  a_order_legal:
    assert property (o_access_order_field != 2'h3) else $error("illegal access order");
  a_cfg_quiet:
    assert property (!o_busy ##1 !o_busy |-> $stable(cfg)) else $error("config moved idle");
  a_wr_own_sub:
    assert property (o_wr_strobe |-> o_busy && o_subaddress_field == OWN_SUBADDR)
    else $error("data stored for other subaddress");
  a_start_busy:
    assert property (s_start |-> ##[1:8] o_busy) else $error("start not seen");
  a_stop_idle:
    assert property (s_stop |-> ##[1:8] !o_busy) else $error("stop not seen");
  a_ack_hold:
    assert property ($rose(o_sda_oe) |-> o_sda_oe[*4]) else $error("low drive too short");
endmodule // lcd_cmd_properties
bind lcd_driver_command_decoder lcd_cmd_properties #(.OWN_SUBADDR(OWN_SUBADDR))
  i_lcd_cmd_properties (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
  .o_multiplex_rate_field(o_multiplex_rate_field),
  .o_display_status_field(o_display_status_field), .o_mixed_mode(o_mixed_mode),
  .o_top_bank_field(o_top_bank_field), .o_subaddress_field(o_subaddress_field),
  .o_access_order_field(o_access_order_field), .o_bank_select_field(o_bank_select_field),
  .o_column_field(o_column_field), .o_wr_strobe(o_wr_strobe), .o_busy(o_busy));
`default_nettype wire

// *** verif/i2c_master_model.sv ***
// Bus master model driving the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // Clock and resolved data line
  input wire logic i_clk_sys,
  input wire logic i_sda,
  // Driven pins
  output logic o_scl,
  output logic o_sda_low
);
  // Two system clocks, a quarter of the 160 ns bus period
  task automatic qp;
    repeat (2) @(negedge i_clk_sys);
  endtask
  // Opens from idle only: SDA falls while SCL high
  task automatic start;
    o_sda_low = 1'b1;
    qp;
    qp;
    o_scl = 1'b0;
  endtask
  // SDA rises while SCL high, then both lines rest released
  task automatic stop;
    qp;
    o_sda_low = 1'b1;
    qp;
    o_scl = 1'b1;
    qp;
    o_sda_low = 1'b0;
    qp;
    qp;
  endtask
  // Eight bits and the ninth acknowledge pulse, data moved only while SCL low.
  // SCL stays low three quarters and high one: the slave's filtered release
  // comes some five clocks after a fall and must settle before the next rise.
  task automatic xb(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      qp;
      o_sda_low = !w[i];
      qp;
      qp;
      o_scl = 1'b1;
      qp;
      r[i] = i_sda;
      o_scl = 1'b0;
    end
  endtask
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
endmodule // i2c_master_model
`default_nettype wire

// *** verif/tb_lcd_driver_command_decoder.sv ***
// Self-checking bench for the LCD command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_driver_command_decoder;
  logic clk = 1'b0;
  logic srst, scl, m_low, sda_o, sda_oe, mix, wr_stb, rd_stb, busy, e_mix;
  logic [1:0] mux, stat, bank, ord, ysel, e_mux, e_stat, e_bank, e_ord, e_ysel;
  logic [3:0] sub, e_sub;
  logic [5:0] col, e_col;
  logic [7:0] rd_data, wr_data, wr_last, d;
  logic [8:0] r;
  logic [7:0] exp_q[$];
  int num_errors = 0, cmp_count = 0, wr_cnt = 0, n;
  // Pull-up resolves the shared data line
  wire sda = !(m_low || (sda_oe && !sda_o));
  initial forever #10 clk = !clk;
  lcd_driver_command_decoder i_lcd_driver_command_decoder (.i_clk_sys(clk), .i_srst(srst),
    .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe), .i_rd_data(rd_data),
    .o_multiplex_rate_field(mux), .o_display_status_field(stat), .o_mixed_mode(mix),
    .o_top_bank_field(bank), .o_subaddress_field(sub), .o_access_order_field(ord),
    .o_bank_select_field(ysel), .o_column_field(col), .o_wr_data(wr_data),
    .o_wr_strobe(wr_stb), .o_rd_strobe(rd_stb), .o_busy(busy));
  i2c_master_model i_i2c_master_model (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(m_low));
  // Record stored bytes and the byte just captured for reading, then offer a new one
  always @(negedge clk) begin
    if (wr_stb === 1'b1) begin
      wr_cnt++;
      wr_last = wr_data;
    end
    if (rd_stb === 1'b1) begin
      exp_q.push_back(rd_data);
      rd_data <= 8'($urandom);
    end
  end
  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic ck(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic cmp_cfg;
    ck({mux, stat, mix, bank, sub, ord, ysel, col} ===
      {e_mux, e_stat, e_mix, e_bank, e_sub, e_ord, e_ysel, e_col}, "config");
  endtask
  // Expected effect of one command byte
  task automatic model(input logic [7:0] b);
    if (!b[6]) begin
      if (b[5:0] <= 6'd39) e_col = b[5:0];
    end else if (!b[5]) {e_mix, e_stat, e_mux} = b[4:0];
    else if (!b[4]) e_sub = b[3:0];
    else if (b[3:2] == 2'h3) e_bank = b[1:0];
    else {e_ord, e_ysel} = b[3:0];
  endtask
  task automatic cmd(input logic [7:0] b);
    i_i2c_master_model.xb({b, 1'b1}, r);
    ck(r[0] === 1'b0, "command ack");
    model(b);
    cmp_cfg();
  endtask
  task automatic open(input logic [7:0] a);
    i_i2c_master_model.start();
    i_i2c_master_model.xb({a, 1'b1}, r);
  endtask
  initial begin
    srst = 1'b1;
    rd_data = 8'h00;
    {e_mux, e_stat, e_mix, e_bank, e_sub, e_ord, e_ysel, e_col} = '0;
    void'($urandom(32'hb285));
    repeat (8) @(negedge clk);
    srst = 1'b0;
    repeat (10) @(negedge clk);
    cmp_cfg();
    open(8'h78);
    ck(r[0] === 1'b0, "address ack");
    for (int k = 0; k < 4; k++) begin
      cmd(8'hc0 | 8'({k[0], k[1:0], k[1:0]}));
      cmd(8'hfc | 8'(k));
      cmd(8'he0 | 8'(k * 5));
      cmd(8'hf0 | 8'({k[1:0], ~k[1:0]}));
    end
    cmd(8'ha7);
    cmd(8'ha8);
    cmd(8'hbf);
    repeat (40) cmd(8'h80 | 8'($urandom));
    cmd(8'h60);
    repeat (3) begin
      d = 8'($urandom) | 8'h80;
      n = wr_cnt;
      i_i2c_master_model.xb({d, 1'b1}, r);
      ck(r[0] === 1'b0 && wr_cnt == n + 1 && wr_last === d, "stored data");
      cmp_cfg();
    end
    i_i2c_master_model.stop();
    repeat (10) @(negedge clk);
    ck(busy === 1'b0, "busy after stop");
    open(8'h78);
    cmd(8'h61);
    n = wr_cnt;
    repeat (2) i_i2c_master_model.xb({8'h5a, 1'b1}, r);
    ck(wr_cnt == n, "foreign subaddress stored");
    i_i2c_master_model.stop();
    open(8'h79);
    ck(r[0] === 1'b0, "read address ack");
    for (int i = 0; i < 3; i++) begin
      i_i2c_master_model.xb({8'hff, i == 2}, r);
      ck(exp_q.size() > 0 && r[8:1] === exp_q.pop_front(), "read data");
    end
    repeat (6) @(negedge clk);
    ck(sda_oe === 1'b0, "line kept after nak");
    i_i2c_master_model.stop();
    cmp_cfg();
    open(8'h7a);
    ck(r[0] === 1'b1, "foreign address ack");
    i_i2c_master_model.xb({8'h27, 1'b1}, r);
    i_i2c_master_model.stop();
    repeat (10) @(negedge clk);
    cmp_cfg();
    ck(busy === 1'b0 && sda_oe === 1'b0, "idle lines");
    test_done();
  end
  // Watchdog against a hung transfer
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule // tb_lcd_driver_command_decoder
`default_nettype wire
